// >>> design/ast_top.sv
// async serial transceiver: AHB-Lite registers, baud generator, tx and rx
// assumes a single-transfer word master and an asynchronous rx pin
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/100ps
module ast_top #(
  parameter int RX_DEPTH = 2  // receive FIFO depth
) (
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire ast_pkg::ast_ahb_req_t ahb_req,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic                   tx_line,
  input  wire logic              rx_line,
  output logic                   receive_irq
);
  import ast_pkg::*;

  localparam int PTR_W = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(RX_DEPTH - 1);
  localparam logic [PTR_W:0]   CNT_FULL = (PTR_W + 1)'(RX_DEPTH);

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} ast_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ast_rx_state_t;

  // software-visible state
  logic [7:0]    tx_buf;       // transmit_data_buffer
  logic          tx_buf_full;  // buffer holds an unsent character
  logic [7:0]    baud_lo;      // low half of baud_divisor_pair
  logic [7:0]    baud_hi;      // high half of baud_divisor_pair
  logic [7:0]    rsc;          // receive_status_control, writable bits
  logic [7:0]    txc;          // transmit control, writable bits
  logic [7:0]    bct;          // baud and flag control, writable bits
  logic          overrun_error_flag;         // overrun_error_flag
  // bus data phase
  logic          dp_act;       // a data phase is waiting on us
  logic          dp_wr;        // that data phase is a write
  logic [IDX_W-1:0] dp_idx;    // register index of that data phase
  // baud generator
  logic [15:0]   baud_cnt;     // divider count
  // transmitter
  ast_tx_state_t tx_state;
  logic [4:0]    tx_sub;       // sub-tick within current bit
  logic [3:0]    tx_bit;       // data bit counter
  logic [8:0]    transmit_shift_register;          // transmit_shift_register
  // receiver
  logic [2:0]    rx_sync;      // pin synchroniser, [0] first stage
  logic          rx_level;     // filtered line level
  ast_rx_state_t rx_state;
  logic [4:0]    rx_sub;       // sub-tick within current bit
  logic [3:0]    rx_bit;       // data bit counter
  logic [8:0]    receive_shift_register;          // receive_shift_register
  logic          rx_done;      // one-cycle: character complete
  ast_rx_entry_t rx_ent;       // completed character
  // receive FIFO
  ast_rx_entry_t fifo_mem [RX_DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0]   fifo_cnt;

  // control decode
  wire serial_port_enable      = rsc[RSC_SERIAL_PORT_ENABLE];
  wire rx9       = rsc[RSC_RX9];
  wire continuous_receive_enable      = rsc[RSC_CONTINUOUS_RECEIVE_ENABLE];
  wire rcie      = bct[BCT_RCIE];
  wire high_baud_select      = txc[TXC_HIGH_BAUD_SELECT];
  wire wide_baud_divider_select     = bct[BCT_WIDE_BAUD_DIVIDER_SELECT];
  // (RULE16) port enable, async only
  wire port_on   = serial_port_enable & ~txc[TXC_SYNC];
  // (RULE13) address detect needs nine bits
  wire address_detect_enable_eff = rsc[RSC_ADDRESS_DETECT_ENABLE] & rx9;
  // (RULE17) receive gated by continuous enable
  wire rx_on     = port_on & continuous_receive_enable & ~overrun_error_flag;
  wire tx_on     = port_on & txc[TXC_TXEN];

  // bus decode
  wire take      = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
  wire wr_now    = dp_act & dp_wr;
  wire rd_now    = dp_act & ~dp_wr;
  wire [7:0] wbyte = ahb_req.hwdata[7:0];
  wire wr_txd    = wr_now & (dp_idx == IDX_TX_DATA);
  wire wr_blo    = wr_now & (dp_idx == IDX_BAUD_LO);
  wire wr_bhi    = wr_now & (dp_idx == IDX_BAUD_HI);
  wire wr_rsc    = wr_now & (dp_idx == IDX_RSC);
  wire wr_txc    = wr_now & (dp_idx == IDX_TXC);
  wire wr_bct    = wr_now & (dp_idx == IDX_BCT);
  wire fifo_ne   = (fifo_cnt != '0);
  wire fifo_full = (fifo_cnt == CNT_FULL);
  // (RULE12) data read advances the FIFO
  wire pop       = rd_now & (dp_idx == IDX_RX_DATA) & fifo_ne;
  ast_rx_entry_t top;
  assign top = fifo_mem[rd_ptr];

  // status views; status flags are ORed onto the stored bits, unused bits read zero
  // (RULE11) ninth bit of oldest entry
  // (RULE19) error flags beside ninth bit
  wire [7:0] ferr_v = fifo_ne ? (8'(top.ferr) << RSC_FERR) : RST_BYTE;
  wire [7:0] received_ninth_bit_v = fifo_ne ? (8'(top.ninth) << RSC_RECEIVED_NINTH_BIT) : RST_BYTE;
  wire [7:0] rsc_v  = rsc | ferr_v | received_ninth_bit_v | (8'(overrun_error_flag) << RSC_OVERRUN_ERROR_FLAG);
  wire [7:0] txc_v  = txc | (8'(!tx_buf_full) << TXC_TBE);
  wire [7:0] bct_v  = bct | (8'(fifo_ne) << BCT_RCIF);
  wire [7:0] rxd_v  = fifo_ne ? top.data : RST_BYTE;
  wire [7:0] rd_val =
    (dp_idx == IDX_RX_DATA) ? rxd_v   :
    (dp_idx == IDX_TX_DATA) ? tx_buf  :
    (dp_idx == IDX_BAUD_LO) ? baud_lo :
    (dp_idx == IDX_BAUD_HI) ? baud_hi :
    (dp_idx == IDX_RSC)     ? rsc_v   :
    (dp_idx == IDX_TXC)     ? txc_v   :
    (dp_idx == IDX_BCT)     ? bct_v   : RST_BYTE;

  // address phase capture; one wait state gives a registered read path
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      dp_act <= 1'b0;
      dp_wr  <= 1'b0;
      dp_idx <= '0;
    end
    else
    begin
      dp_act <= take;
      if (take)
      begin
        dp_wr  <= ahb_req.hwrite;
        dp_idx <= ahb_req.haddr[IDX_W+1:2];
      end
    end
  end

  // data phase answer; response is always OKAY
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      hreadyout <= 1'b1;
      hrdata    <= '0;
      hresp     <= HRESP_OKAY;
    end
    else
    begin
      hreadyout <= ~take;
      hresp     <= HRESP_OKAY;
      if (rd_now)
        hrdata <= {24'h000000, rd_val};
    end
  end

  // configuration registers
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      baud_lo <= RST_BYTE;
      baud_hi <= RST_BYTE;
      rsc     <= RST_BYTE;
      txc     <= RST_BYTE;
      bct     <= RST_BYTE;
    end
    else
    begin
      if (wr_blo)
        baud_lo <= wbyte;
      if (wr_bhi)
        baud_hi <= wbyte;
      if (wr_rsc)
        rsc <= wbyte & RSC_WMASK;
      if (wr_txc)
        txc <= wbyte & TXC_WMASK;
      if (wr_bct)
        bct <= wbyte & BCT_WMASK;
    end
  end

  // (RULE5) divider 8 or 16 bits wide
  // (RULE7) one tick feeds both directions
  wire [15:0] div_lim = wide_baud_divider_select ? {baud_hi, baud_lo} : {8'h00, baud_lo};
  wire        tick    = port_on & (baud_cnt >= div_lim);
  wire [4:0]  ovs     = high_baud_select ? OVS_HIGH : OVS_LOW;
  wire [4:0]  ovs_end = ovs - 5'h01;
  wire [4:0]  half_end = {1'b0, ovs[4:1]} - 5'h01;

  // free-running divider, held clear while the port is off
  always_ff @(posedge mclk)
  begin
    if (!reset_n || !port_on)
      baud_cnt <= RST_WORD;
    else if (tick)
      baud_cnt <= RST_WORD;
    else
      baud_cnt <= baud_cnt + 16'h0001;
  end

  // transmitter
  // (RULE9) shift register loads only from buffer
  wire       tx_load  = (tx_state == TX_IDLE) & tx_on & tx_buf_full & tick;
  wire       tx_bend  = tick & (tx_sub == ovs_end);
  wire [3:0] tx_nbits = txc[TXC_TX9] ? NBITS_9 : NBITS_8;

  // (RULE21) transmit data register, reset zero
  // a write in the load cycle refills the buffer, so full stays set
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      tx_buf      <= RST_BYTE;
      tx_buf_full <= 1'b0;
    end
    else if (wr_txd)
    begin
      tx_buf      <= wbyte;
      tx_buf_full <= 1'b1;
    end
    else if (tx_load)
      tx_buf_full <= 1'b0;
  end

  // frame sequencer; line changes only at bit boundaries
  always_ff @(posedge mclk)
  begin
    if (!reset_n || !tx_on)
    begin
      tx_state <= TX_IDLE;
      tx_sub   <= '0;
      tx_bit   <= '0;
      transmit_shift_register      <= '0;
      // (RULE1) idle at mark
      tx_line  <= 1'b1;
    end
    else
    begin
      if (tick)
        tx_sub <= tx_bend ? 5'h00 : tx_sub + 5'h01;
      case (tx_state)
        TX_IDLE:
        begin
          tx_sub <= '0;
          if (tx_load)
          begin
            // (RULE8) ninth bit is software data
            transmit_shift_register      <= {txc[TXC_TX9D], tx_buf};
            // (RULE3) start bit at space
            tx_line  <= 1'b0;
            tx_state <= TX_START;
          end
        end
        // (RULE4) each bit spans ovs ticks
        TX_START:
          if (tx_bend)
          begin
            tx_line  <= transmit_shift_register[0];
            tx_bit   <= '0;
            tx_state <= TX_DATA;
          end
        TX_DATA:
          if (tx_bend)
          begin
            // (RULE6) shift out LSb first
            transmit_shift_register    <= {1'b0, transmit_shift_register[8:1]};
            tx_bit <= tx_bit + 4'h1;
            if (tx_bit == tx_nbits - 4'h1)
            begin
              // (RULE2) one stop bit ends frame
              tx_line  <= 1'b1;
              tx_state <= TX_STOP;
            end
            else
              tx_line <= transmit_shift_register[1];
          end
        TX_STOP:
          if (tx_bend)
            tx_state <= TX_IDLE;
        default:
          tx_state <= TX_IDLE;
      endcase
    end
  end

  // pin synchroniser; a level counts once stages two and three agree
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      rx_sync  <= 3'h7;
      rx_level <= 1'b1;
    end
    else
    begin
      rx_sync <= {rx_sync[1:0], rx_line};
      if (rx_sync[1] == rx_sync[2])
        rx_level <= rx_sync[2];
    end
  end

  // receiver
  wire       rx_bend  = tick & (rx_sub == ovs_end);
  wire       rx_hend  = tick & (rx_sub == half_end);
  wire [3:0] rx_nbits = rx9 ? NBITS_9 : NBITS_8;

  // character sequencer; a false start returns to idle
  always_ff @(posedge mclk)
  begin
    if (!reset_n || !rx_on)
    begin
      rx_state <= RX_IDLE;
      rx_sub   <= '0;
      rx_bit   <= '0;
      receive_shift_register      <= '0;
      rx_done  <= 1'b0;
      rx_ent   <= '0;
    end
    else
    begin
      rx_done <= 1'b0;
      if (tick)
        rx_sub <= rx_bend ? 5'h00 : rx_sub + 5'h01;
      case (rx_state)
        // (RULE23) falling edge starts a character
        RX_IDLE:
        begin
          rx_sub <= '0;
          if (tick && !rx_level)
            rx_state <= RX_START;
        end
        // (RULE23) recheck start at mid-bit
        RX_START:
          if (rx_hend)
          begin
            rx_sub   <= '0;
            rx_bit   <= '0;
            rx_state <= rx_level ? RX_IDLE : RX_DATA;
          end
        RX_DATA:
          if (rx_bend)
          begin
            // (RULE10) eight or nine shifts, LSb first
            receive_shift_register    <= {rx_level, receive_shift_register[8:1]};
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == rx_nbits - 4'h1)
              rx_state <= RX_STOP;
          end
        RX_STOP:
          if (rx_bend)
          begin
            // (RULE3) space in stop bit is framing error
            rx_ent.ferr  <= ~rx_level;
            rx_ent.ninth <= rx9 & receive_shift_register[8];
            rx_ent.data  <= rx9 ? receive_shift_register[7:0] : receive_shift_register[8:1];
            rx_done      <= 1'b1;
            rx_state     <= RX_IDLE;
          end
        default:
          rx_state <= RX_IDLE;
      endcase
    end
  end

  // (RULE14) drop characters with ninth bit clear
  // (RULE15) software may clear detect after match
  wire rx_keep  = rx_done & (~address_detect_enable_eff | rx_ent.ninth);
  // (RULE22) full FIFO means overrun, no store
  wire ovr_set  = rx_keep & fifo_full;
  wire push     = rx_keep & ~fifo_full;

  // receive FIFO storage
  // (RULE18) entry arrival sets the receive flag
  always_ff @(posedge mclk)
  begin
    if (push)
      fifo_mem[wr_ptr] <= rx_ent;
  end

  // FIFO pointers and count
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      fifo_cnt <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + PTR_W'(1);
      if (pop)
        rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + PTR_W'(1);
      if (push && !pop)
        fifo_cnt <= fifo_cnt + (PTR_W + 1)'(1);
      else if (pop && !push)
        fifo_cnt <= fifo_cnt - (PTR_W + 1)'(1);
    end
  end

  // overrun flag; a new overrun wins over the clear
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      overrun_error_flag <= 1'b0;
    else if (ovr_set)
      overrun_error_flag <= 1'b1;
    // (RULE20) clearing receive enable clears overrun
    else if (!continuous_receive_enable)
      overrun_error_flag <= 1'b0;
  end

  // (RULE18) interrupt follows flag when enabled
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      receive_irq <= 1'b0;
    else
      receive_irq <= fifo_ne & rcie;
  end

endmodule // ast_top

// >>> design/ast_pkg.sv
// constants, field layouts and carrier types of the async serial transceiver
// assumes one 32-bit AHB-Lite slave port and a single system clock
// Contract
// (RULE1) transmit line idles at mark, NRZ
// (RULE2) frame: start, 8 or 9 data, stop
// (RULE3) start bit space, stop bits mark
// (RULE4) every transmitted bit lasts one bit period
// (RULE5) baud divider selectable 8 or 16 bits
// (RULE6) data bits travel LSb first
// (RULE7) independent directions, shared format and baud
// (RULE8) no hardware parity; ninth bit is software's
// (RULE9) shift register loads only from transmit buffer
// (RULE10) nine-bit select shifts nine bits per character
// (RULE11) ninth-bit status shows oldest unread character
// (RULE12) software reads ninth bit before data
// (RULE13) address detect works only with nine bits
// (RULE14) address detect keeps ninth-bit-set characters only
// (RULE15) software clears address detect after match
// (RULE16) port enable on, synchronous select off
// (RULE17) receive only while continuous receive enabled
// (RULE18) receive flag on FIFO entry, gated interrupt
// (RULE19) status shows error flags and ninth bit
// (RULE20) clearing continuous receive clears overrun
// (RULE21) eight-bit transmit data register, reset zero
// (RULE22) full FIFO at completion sets overrun, stops
// (RULE23) start on falling edge, sample mid-bit
package ast_pkg;
  // register indices; byte address is four times the index
  localparam int unsigned     IDX_W       = 10;
  localparam logic [IDX_W-1:0] IDX_RX_DATA = 10'h119;
  localparam logic [IDX_W-1:0] IDX_TX_DATA = 10'h11a;
  localparam logic [IDX_W-1:0] IDX_BAUD_LO = 10'h11b;
  localparam logic [IDX_W-1:0] IDX_BAUD_HI = 10'h11c;
  localparam logic [IDX_W-1:0] IDX_RSC     = 10'h11d;
  localparam logic [IDX_W-1:0] IDX_TXC     = 10'h11e;
  localparam logic [IDX_W-1:0] IDX_BCT     = 10'h11f;
  // receive_status_control bits
  localparam int RSC_SERIAL_PORT_ENABLE  = 7;
  localparam int RSC_RX9   = 6;
  localparam int RSC_CONTINUOUS_RECEIVE_ENABLE  = 4;
  localparam int RSC_ADDRESS_DETECT_ENABLE = 3;
  localparam int RSC_FERR  = 2;
  localparam int RSC_OVERRUN_ERROR_FLAG  = 1;
  localparam int RSC_RECEIVED_NINTH_BIT  = 0;
  localparam logic [7:0] RSC_WMASK = 8'hd8;
  // transmit control bits
  localparam int TXC_TX9  = 6;
  localparam int TXC_TXEN = 5;
  localparam int TXC_SYNC = 4;
  localparam int TXC_HIGH_BAUD_SELECT = 2;
  localparam int TXC_TBE  = 1;
  localparam int TXC_TX9D = 0;
  localparam logic [7:0] TXC_WMASK = 8'h75;
  // baud and flag control bits
  localparam int BCT_RCIE  = 5;
  localparam int BCT_RCIF  = 4;
  localparam int BCT_WIDE_BAUD_DIVIDER_SELECT = 3;
  localparam logic [7:0] BCT_WMASK = 8'h28;
  // reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // sub-ticks per bit, and data bits per character
  localparam logic [4:0] OVS_LOW   = 5'h10;
  localparam logic [4:0] OVS_HIGH  = 5'h04;
  localparam logic [3:0] NBITS_8   = 4'h8;
  localparam logic [3:0] NBITS_9   = 4'h9;
  localparam logic       HRESP_OKAY = 1'b0;
  // AHB-Lite request seen by the slave
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
  } ast_ahb_req_t;
  // one receive FIFO entry
  typedef struct packed {
    logic       ferr;
    logic       ninth;
    logic [7:0] data;
  } ast_rx_entry_t;
endpackage

// >>> sim/ast_top_properties.sv
// checker of bus timing, serial line shape and irq of ast_top
// assumes the bench programs a bit period of BIT_CYC mclk cycles
`timescale 1ns/100ps
module ast_chk #(
  parameter int RX_DEPTH = 2,  // fifo depth, mirrored from the top
  parameter int BIT_CYC  = 8   // mclk cycles per bit as programmed
) (
  input wire logic                  mclk,
  input wire logic                  reset_n,
  input wire ast_pkg::ast_ahb_req_t ahb_req,
  input wire logic [31:0]           hrdata,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire logic                  tx_line,
  input wire logic                  rx_line,
  input wire logic                  receive_irq
);
  import ast_pkg::*;
  localparam int LOW_MAX = 10 * BIT_CYC;  // start plus nine zero data bits
  wire        taken;    // address phase accepted
  logic       rd_ph;    // read data phase open
  logic [7:0] low_cnt;  // cycles tx_line has stayed low
  assign taken = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
  // remember whether the open data phase is a read
  always_ff @(posedge mclk)
  begin
    if (!reset_n) rd_ph <= 1'b0;
    else if (taken) rd_ph <= !ahb_req.hwrite;
    else if (hreadyout) rd_ph <= 1'b0;
  end
  // low run length; a stuck line trips the bound long before a wrap
  always_ff @(posedge mclk)
  begin
    if (!reset_n || tx_line) low_cnt <= 8'h00;
    else low_cnt <= low_cnt + 8'h01;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_reset_mark: assert property ($rose(reset_n) |-> tx_line)
    else $error("tx_line not at mark after reset");
  a_bit_period: assert property ($changed(tx_line) |=> $stable(tx_line)[*7])
    else $error("tx bit shorter than one period");
  a_low_bound: assert property (low_cnt <= LOW_MAX)
    else $error("tx low longer than start and nine bits");
  a_one_wait: assert property (taken |=> !hreadyout ##1 hreadyout)
    else $error("bus answer not after one wait state");
  a_upper_zero: assert property (hreadyout |-> hrdata[31:8] == 24'h000000)
    else $error("read data wider than a byte");
  a_read_hold: assert property ($changed(hrdata) |-> $past(rd_ph) && !$past(hreadyout))
    else $error("read data changed outside a read");
  a_resp_okay: assert property (hresp == HRESP_OKAY)
    else $error("bus response not okay");
  a_irq_pop: assert property ($fell(receive_irq) |-> !$past(hreadyout, 2))
    else $error("irq dropped without a bus access");
  c_tx_frame: cover property ($fell(tx_line));
  c_rx_irq: cover property ($rose(receive_irq));
  c_bus_read: cover property (taken && !ahb_req.hwrite);
endmodule // ast_chk
bind ast_top ast_chk #(.RX_DEPTH(RX_DEPTH)) chk_u (.mclk(mclk), .reset_n(reset_n),
  .ahb_req(ahb_req), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .tx_line(tx_line), .rx_line(rx_line), .receive_irq(receive_irq));

// >>> sim/ast_remote.sv
// remote serial node: sends frames on rx_line, captures frames from tx_line
// assumes both ends use BIT_CYC mclk cycles per bit
`timescale 1ns/100ps
module ast_remote #(
  parameter int BIT_CYC = 8  // mclk cycles per bit
) (
  input  wire logic mclk,
  input  wire logic tx_line,
  output logic      rx_line
);
  logic [8:0] got_q [$];  // captured frames, bit 8 is ninth bit or stop
  initial rx_line = 1'b1;
  // sample mid-bit; nine bits taken, so in 8-bit frames bit 8 is the stop
  initial
  begin : catcher
    logic [8:0] w;
    forever
    begin
      @(negedge tx_line);
      repeat (BIT_CYC / 2) @(posedge mclk);
      for (int i = 0; i < 9; i++)
      begin
        repeat (BIT_CYC) @(posedge mclk);
        w[i] = tx_line;
      end
      got_q.push_back(w);
    end
  end
  // start space, data LSb first, stop mark
  task automatic send_char(input logic [8:0] bits, input int nb);
    @(posedge mclk) rx_line <= 1'b0;
    repeat (BIT_CYC - 1) @(posedge mclk);
    for (int i = 0; i < nb; i++)
    begin
      @(posedge mclk) rx_line <= bits[i];
      repeat (BIT_CYC - 1) @(posedge mclk);
    end
    @(posedge mclk) rx_line <= 1'b1;
    repeat (BIT_CYC - 1) @(posedge mclk);
  endtask
endmodule // ast_remote

// >>> sim/tb_top.sv
// bench: registers over AHB-Lite, frames to and from a remote node
// assumes divisor 1 with high_baud_select, so one bit is 8 mclk
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tb_top;
  import ast_pkg::*;
  logic         mclk, reset_n;              // clock and reset
  ast_ahb_req_t req_q, bus;                 // driven request, request with hready
  logic [31:0]  hrdata, d;                  // bus read data, last read
  logic         hreadyout, hresp, tx_line, rx_line, receive_irq;
  int           mismatches, checks;         // verdict counters
  logic [8:0]   f;                          // last frame taken from the remote
  // hready of the bus is the single slave's hreadyout
  always_comb
  begin
    bus = req_q;
    bus.hready = hreadyout;
  end
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  ast_top #(.RX_DEPTH(2)) dut_u (.mclk(mclk), .reset_n(reset_n), .ahb_req(bus),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tx_line(tx_line),
    .rx_line(rx_line), .receive_irq(receive_irq));
  ast_remote #(.BIT_CYC(8)) remote_u (.mclk(mclk), .tx_line(tx_line), .rx_line(rx_line));
  task final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // edge where hready is seen high ends a phase; wait states are polled for up to 50 cycles
  task automatic wait_rdy;
    for (int n = 0; n < 50; n++)
    begin
      @(posedge mclk);
      if (hreadyout === 1'b1) return;
    end
    mismatches++;
    final_report();
  endtask
  // one single word transfer; read data lands in d
  task automatic xfer(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    @(posedge mclk);
    req_q.hsel <= 1'b1;
    req_q.haddr <= {20'h00000, idx, 2'b00};
    req_q.htrans <= 2'b10;
    req_q.hwrite <= wr;
    req_q.hsize <= 3'b010;
    wait_rdy();
    req_q.hsel <= 1'b0;
    req_q.htrans <= 2'b00;
    req_q.hwdata <= {24'h000000, wd};
    wait_rdy();
    d = hrdata;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] v); xfer(1'b1, idx, v); endtask
  task automatic rd(input logic [9:0] idx); xfer(1'b0, idx, 8'h00); endtask
  task automatic wait_irq(input logic lvl);
    for (int n = 0; n < 600; n++)
    begin
      @(posedge mclk);
      if (receive_irq === lvl) return;
    end
    mismatches++;
    final_report();
  endtask
  // frames from the device arrive in the remote's queue
  task automatic wait_got;
    for (int n = 0; n < 1000; n++)
    begin
      @(posedge mclk);
      if (remote_u.got_q.size() > 0)
      begin
        f = remote_u.got_q.pop_front();
        return;
      end
    end
    mismatches++;
    final_report();
  endtask
  task automatic t_regs;
    `CHK("tx_line idle", 1'b1, tx_line)
    rd(IDX_TX_DATA); `CHK("tx data reset", 32'h0, d)
    wr(IDX_TX_DATA, 8'ha5); rd(IDX_TX_DATA); `CHK("tx data rw", 32'ha5, d)
    rd(10'h000); `CHK("unmapped", 32'h0, d)
    wr(IDX_BAUD_HI, 8'h01); // narrow divider must ignore this half
    wr(IDX_BAUD_LO, 8'h01); wr(IDX_BCT, 8'h20); wr(IDX_RSC, 8'h90);
    rd(IDX_RSC); `CHK("rx control", 32'h90, d)
  endtask
  // buffered byte leaves at enable; 3c refills the buffer at once, 96 waits for buffer empty
  task automatic t_tx;
    wr(IDX_TXC, 8'h24); wr(IDX_TX_DATA, 8'h3c);
    rd(IDX_TXC); `CHK("buffer full", 32'h24, d)
    for (int n = 0; n < 60 && d[TXC_TBE] !== 1'b1; n++) rd(IDX_TXC);
    `CHK("buffer empty", 1'b1, d[TXC_TBE])
    wr(IDX_TX_DATA, 8'h96);
    wait_got(); `CHK("frame a5", 9'h1a5, f)
    wait_got(); `CHK("frame 3c", 9'h13c, f)
    wait_got(); `CHK("frame 96", 9'h196, f)
    wr(IDX_TXC, 8'h65); wr(IDX_TX_DATA, 8'h00);
    wait_got(); `CHK("ninth one", 9'h100, f)
    wr(IDX_TXC, 8'h64); wr(IDX_TX_DATA, 8'h00);
    wait_got(); `CHK("ninth zero", 9'h000, f)
    // let the stop bit finish, then the synchronous select must hold the port off
    repeat (16) @(posedge mclk);
    wr(IDX_TXC, 8'h34);
    wr(IDX_TX_DATA, 8'h5a);
    repeat (40) @(posedge mclk);
    `CHK("sync holds mark", 1'b1, tx_line)
    wr(IDX_TXC, 8'h24);
    wait_got(); `CHK("frame after sync", 9'h15a, f)
  endtask
  task automatic t_rx_basic;
    remote_u.send_char(9'h0c3, 8);
    wait_irq(1'b1);
    wr(IDX_BCT, 8'h00); @(posedge mclk); `CHK("irq masked", 1'b0, receive_irq)
    rd(IDX_BCT); `CHK("rx flag", 32'h10, d)
    wr(IDX_BCT, 8'h20); rd(IDX_RX_DATA); `CHK("rx c3", 32'hc3, d)
    wait_irq(1'b0);
  endtask
  // address detect drops a ninth-bit-zero character
  task automatic t_rx_addr;
    wr(IDX_RSC, 8'hd8);
    remote_u.send_char(9'h055, 9); remote_u.send_char(9'h1a7, 9);
    wait_irq(1'b1);
    rd(IDX_RSC); `CHK("ninth status", 32'hd9, d)
    rd(IDX_RX_DATA); `CHK("address kept", 32'ha7, d)
    rd(IDX_RX_DATA); `CHK("data dropped", 32'h0, d)
    // address matched: software drops detect, so plain characters arrive
    wr(IDX_RSC, 8'hd0);
    remote_u.send_char(9'h055, 9);
    wait_irq(1'b1);
    rd(IDX_RSC); `CHK("ninth read first", 32'hd0, d)
    rd(IDX_RX_DATA); `CHK("detect off keeps", 32'h55, d)
  endtask
  task automatic t_overrun;
    wr(IDX_RSC, 8'h98); // detect without nine bits keeps all
    remote_u.send_char(9'h011, 8); remote_u.send_char(9'h022, 8);
    remote_u.send_char(9'h033, 8);
    for (int n = 0; n < 20 && d[RSC_OVERRUN_ERROR_FLAG] !== 1'b1; n++) rd(IDX_RSC);
    `CHK("overrun set", 32'h9a, d)
    wr(IDX_RSC, 8'h80); rd(IDX_RSC); `CHK("overrun clear", 32'h80, d)
    rd(IDX_RX_DATA); `CHK("first kept", 32'h11, d)
    rd(IDX_RX_DATA); `CHK("second kept", 32'h22, d)
    rd(IDX_RX_DATA); `CHK("third lost", 32'h0, d)
    remote_u.send_char(9'h044, 8);
    repeat (16) @(posedge mclk);
    `CHK("rx off irq", 1'b0, receive_irq)
    rd(IDX_RX_DATA); `CHK("rx off data", 32'h0, d)
  endtask
  // reset for 20 cycles, then the scenarios in turn
  initial
  begin
    req_q = '0;
    reset_n = 1'b0;
    mismatches = 0;
    checks = 0;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    t_regs();
    t_tx();
    t_rx_basic();
    t_rx_addr();
    t_overrun();
    final_report();
  end
endmodule // tb_top
